// file: core/moc_regs.vh
// Register indices, field positions, reset values and encodings for the on-board memory control block.
`ifndef MOC_REGS_VH
`define MOC_REGS_VH

// Register indices; the byte address on the register bus is four times the index.
`define MOC_CTRL_IDX      8'h16
`define MOC_STAT_IDX      8'h17
`define MOC_IDX_W         8

// Control register fields.
`define MOC_SEG_LSB       0
`define MOC_SEG_W         4
`define MOC_ROM_OFF_BIT   5
`define MOC_CTRL_W        8
`define MOC_CTRL_RESET    8'h4f

// Segment and overlay decode.
`define MOC_SEG_SEL_MSB   15
`define MOC_SEG_SEL_LSB   14
`define MOC_ROM_PAGE      4'hf

// Refresh row width: 128 rows.
`define MOC_ROW_W         7
`define MOC_COL_W         9

// Bus response codes.
`define MOC_RESP_OKAY     2'b00
`define MOC_RESP_SLVERR   2'b10

`endif

// file: core/moc_refresh_row.v
// Refresh row counter that steps once per refresh cycle.
`default_nettype none

module moc_refresh_row #(
  parameter ROW_W = 7
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             step,
  output reg  [ROW_W-1:0] row_q
);

  ////////////////////////////////////////////////////////////////////////////
  // The counter wraps through every row, so 128 steps cover the whole array.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= {ROW_W{1'b0}};
    end else if (step) begin
      row_q <= row_q + {{(ROW_W-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// file: core/moc_memory_control.v
// On-board dynamic RAM control with segment enables, refresh, DMA access and monitor ROM overlay.
`include "moc_regs.vh"
`default_nettype none

module moc_memory_control #(
  parameter ROW_W = `MOC_ROW_W,
  parameter COL_W = `MOC_COL_W
) (
  input  wire             clock,
  input  wire             rst_n,
  // Register bus, AXI4-Lite slave.
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // Processor and backplane memory cycle.
  input  wire [15:0]      mem_addr,
  input  wire             mem_req,
  input  wire             mem_rd,
  input  wire             mem_wr,
  input  wire             opcode_fetch_cycle,
  input  wire             cpu_wait,
  input  wire             dma_active,
  input  wire             cpu_reset_n,
  // Decode results and DRAM strobes.
  output reg              ram_select_q,
  output reg              rom_select_q,
  output reg              data_oe_q,
  output reg              dram_ras_n_q,
  output reg              dram_cas_n_q,
  output reg              dram_we_n_q,
  output reg  [ROW_W-1:0] dram_row_q,
  output reg  [COL_W-1:0] dram_col_q,
  output reg              refresh_active_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Cycle states.
  localparam [2:0] ST_IDLE = 3'd0;  // Array idle, precharged.
  localparam [2:0] ST_RAS  = 3'd1;  // Row strobed for an access.
  localparam [2:0] ST_CAS  = 3'd2;  // Column strobed, held until the cycle ends.
  localparam [2:0] ST_REF  = 3'd3;  // Row-only refresh strobe.
  localparam [2:0] ST_PRE  = 3'd4;  // Precharge before the next cycle.

  reg  [2:0]              state_q;        // Current cycle state.
  reg  [`MOC_CTRL_W-1:0]  ctrl_q;         // Segment enables and overlay switch.
  reg                     pend_ref_q;     // Refresh owed after an opcode fetch.
  reg                     fetch_q;        // Current access is an opcode fetch.
  reg                     rst_s1_q;       // Reset pin synchroniser, first stage.
  reg                     rst_s2_q;       // Second stage.
  reg                     rst_s3_q;       // Third stage.
  reg                     cpu_in_reset_q; // Filtered processor reset level.
  wire [ROW_W-1:0]        ref_row;        // Row for the next refresh.
  wire                    ref_step;       // One refresh issued.

  ////////////////////////////////////////////////////////////////////////////
  // The processor reset pin is asynchronous to us; a new level counts only
  // once stages two and three agree, which rejects single-cycle glitches.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q       <= 1'b0;
      rst_s2_q       <= 1'b0;
      rst_s3_q       <= 1'b0;
      cpu_in_reset_q <= 1'b1;
    end else begin
      rst_s1_q <= ~cpu_reset_n;
      rst_s2_q <= rst_s1_q;
      rst_s3_q <= rst_s2_q;
      if (rst_s2_q == rst_s3_q) begin
        cpu_in_reset_q <= rst_s3_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode. The overlay is checked first so it shadows the RAM.
  wire       rom_on  = ~ctrl_q[`MOC_ROM_OFF_BIT];
  wire       rom_hit = rom_on & (mem_addr[15:12] == `MOC_ROM_PAGE);
  wire [1:0] seg_idx = mem_addr[`MOC_SEG_SEL_MSB:`MOC_SEG_SEL_LSB];
  wire       seg_on  = ctrl_q[`MOC_SEG_LSB + seg_idx];
  wire       ram_hit = seg_on & ~rom_hit;
  wire       acc_go  = mem_req & (mem_rd | mem_wr) & ram_hit;
  // Refresh is owed after a fetch, and runs freely while the processor is
  // stalled or held in reset. A DMA master owns the array, so its own
  // low-order row sweep does the refreshing instead.
  wire       ref_go  = pend_ref_q | cpu_in_reset_q | (cpu_wait & ~dma_active);

  assign ref_step = (state_q == ST_IDLE) & ref_go & ~(acc_go & ~pend_ref_q);

  moc_refresh_row #(
    .ROW_W (ROW_W)
  ) u_row (
    .clock (clock),
    .rst_n (rst_n),
    .step  (ref_step),
    .row_q (ref_row)
  );

  ////////////////////////////////////////////////////////////////////////////
  // DRAM cycle sequencer. An owed post-fetch refresh beats a new access so
  // the row sweep keeps pace with instruction flow.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= ST_IDLE;
      dram_ras_n_q     <= 1'b1;
      dram_cas_n_q     <= 1'b1;
      dram_we_n_q      <= 1'b1;
      dram_row_q       <= {ROW_W{1'b0}};
      dram_col_q       <= {COL_W{1'b0}};
      refresh_active_q <= 1'b0;
      pend_ref_q       <= 1'b0;
      fetch_q          <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ref_step) begin
            // Row-only refresh from the counter.
            dram_row_q       <= ref_row;
            dram_ras_n_q     <= 1'b0;
            refresh_active_q <= 1'b1;
            pend_ref_q       <= 1'b0;
            state_q          <= ST_REF;
          end else if (acc_go) begin
            // Low address bits form the row.
            dram_row_q   <= mem_addr[ROW_W-1:0];
            dram_col_q   <= mem_addr[15:ROW_W];
            dram_we_n_q  <= ~mem_wr;
            dram_ras_n_q <= 1'b0;
            fetch_q      <= opcode_fetch_cycle;
            state_q      <= ST_RAS;
          end
        end
        ST_RAS: begin
          dram_cas_n_q <= 1'b0;
          state_q      <= ST_CAS;
        end
        ST_CAS: begin
          // Hold the strobes until the bus cycle ends.
          if (!mem_req) begin
            dram_ras_n_q <= 1'b1;
            dram_cas_n_q <= 1'b1;
            dram_we_n_q  <= 1'b1;
            pend_ref_q   <= fetch_q;
            state_q      <= ST_PRE;
          end
        end
        ST_REF: begin
          dram_ras_n_q     <= 1'b1;
          refresh_active_q <= 1'b0;
          state_q          <= ST_PRE;
        end
        ST_PRE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selects and data drive. A disabled segment asserts nothing outside the overlay page so an
  // external board can answer without contention.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ram_select_q <= 1'b0;
      rom_select_q <= 1'b0;
      data_oe_q    <= 1'b0;
    end else begin
      ram_select_q <= mem_req & ram_hit;
      rom_select_q <= mem_req & rom_hit;
      data_oe_q    <= mem_req & mem_rd & (ram_hit | rom_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, write side. Address and data are taken in either order and
  // the response waits for both. Only one write is outstanding at a time.
  reg        aw_held_q;  // Write address captured.
  reg [7:0]  aw_addr_q;  // Captured write address.
  reg        w_held_q;   // Write data captured.
  reg [7:0]  w_data_q;   // Captured low byte.
  reg        w_strb_q;   // Captured lane-0 strobe.

  assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;

  // Byte addresses are four times the index; both still fit the 8-bit bus address.
  wire [7:0] ctrl_addr = `MOC_CTRL_IDX << 2;
  wire [7:0] stat_addr = `MOC_STAT_IDX << 2;
  wire       wr_fire   = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire       wr_ctrl   = wr_fire & (aw_addr_q == ctrl_addr);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q    <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_held_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_strb_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MOC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == ctrl_addr) ? `MOC_RESP_OKAY : `MOC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register. A held processor reset forces the overlay back on;
  // this wins over a software write in the same cycle.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `MOC_CTRL_RESET & ~(8'h01 << `MOC_ROM_OFF_BIT);
    end else if (cpu_in_reset_q) begin
      ctrl_q[`MOC_ROM_OFF_BIT] <= 1'b0;
    end else if (wr_ctrl && w_strb_q) begin
      ctrl_q <= w_data_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus, read side. One read at a time; the answer follows a cycle
  // after the address is taken.
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MOC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == ctrl_addr) begin
        s_axi_rdata <= {24'h00_0000, ctrl_q};
        s_axi_rresp <= `MOC_RESP_OKAY;
      end else if (s_axi_araddr == stat_addr) begin
        // Live state: sequencer, row counter, refresh owed, reset seen.
        s_axi_rdata <= {16'h0000, 2'b00, cpu_in_reset_q, pend_ref_q, 1'b0, state_q,
                        1'b0, ref_row};
        s_axi_rresp <= `MOC_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `MOC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: dv/moc_memory_control_monitor.sv
// Port checker for the memory control block.
`default_nettype none
module moc_memory_control_monitor #(parameter int ROW_W = 7, parameter int COL_W = 9) (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic [15:0]      mem_addr,
  input wire logic             mem_req,
  input wire logic             mem_wr,
  input wire logic             dram_we_n_q,
  input wire logic [COL_W-1:0] dram_col_q,
  input wire logic             ram_select_q,
  input wire logic             rom_select_q,
  input wire logic             data_oe_q,
  input wire logic             dram_ras_n_q,
  input wire logic             dram_cas_n_q,
  input wire logic [ROW_W-1:0] dram_row_q,
  input wire logic             refresh_active_q,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Expected refresh row; the sweep must step by one row per refresh cycle.
  logic [ROW_W-1:0] exp_row_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      exp_row_q <= '0;
    end else if (refresh_active_q) begin
      exp_row_q <= exp_row_q + 1'b1;
    end
  end
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_row_step: assert property (refresh_active_q |-> dram_row_q == exp_row_q)
    else $error("refresh row skipped");
  a_col_high: assert property ($fell(dram_ras_n_q) && !refresh_active_q |->
    dram_col_q == $past(mem_addr[15:7]))
    else $error("column not high bits");
  a_we_dir: assert property ($fell(dram_ras_n_q) && !refresh_active_q |-> dram_we_n_q == !$past(mem_wr))
    else $error("write strobe wrong");
  a_rom_range: assert property (rom_select_q |-> $past(mem_req) && $past(mem_addr[15:12]) == 4'hf)
    else $error("rom select off range");
  a_oe_decoded: assert property (data_oe_q |-> ram_select_q || rom_select_q)
    else $error("data out without select");
  a_strobe_sel: assert property ($fell(dram_ras_n_q) && !refresh_active_q |-> ram_select_q)
    else $error("strobe without select");
  a_row_low: assert property ($fell(dram_ras_n_q) && !refresh_active_q |-> dram_row_q == $past(mem_addr[6:0]))
    else $error("row not low bits");
  a_cas_next: assert property ($fell(dram_ras_n_q) && !refresh_active_q |=> !dram_cas_n_q)
    else $error("no column strobe");
  // RAS must stay low once CAS is down while the cycle is still requested.
  a_strobe_hold: assert property (!dram_cas_n_q && mem_req |=> !dram_ras_n_q)
    else $error("strobe dropped early");
  a_ref_pulse: assert property (refresh_active_q |-> !dram_ras_n_q && dram_cas_n_q ##1 dram_ras_n_q)
    else $error("bad refresh pulse");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule
bind moc_memory_control moc_memory_control_monitor #(.ROW_W(ROW_W), .COL_W(COL_W)) u_mon (.clock, .rst_n,
  .mem_addr, .mem_req, .mem_wr, .dram_we_n_q, .dram_col_q,
  .ram_select_q, .rom_select_q, .data_oe_q, .dram_ras_n_q, .dram_cas_n_q, .dram_row_q, .refresh_active_q,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// file: dv/moc_host_model.sv
// Processor and backplane DMA master making memory cycles.
`default_nettype none
module moc_host_model (
  input  wire logic        clock,
  input  wire logic        ram_sel,
  input  wire logic        rom_sel,
  input  wire logic        oe,
  input  wire logic        ref_act,
  output var  logic [15:0] addr,
  output var  logic        req,
  output var  logic        rd,
  output var  logic        wr,
  output var  logic        fetch,
  output var  logic        waitc,
  output var  logic        dma,
  output var  logic        cpu_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, req, rd, wr, fetch, waitc, dma, cpu_rst_n} = {16'h5555, 6'h00, 1'b1};
  // One cycle of 5 clocks; gathers {ram, rom, oe} and counts refreshes.
  task automatic cyc(input logic [15:0] a, input logic r, f, d, output logic [2:0] s, output int rf);
    s = '0;
    rf = 0;
    @(posedge clock);
    {addr, req, rd, wr, fetch, dma} <= {a, 1'b1, r, !r, f, d};
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      // A released bus shows the inverse so stale values never pass.
      if (i == 4) {addr, req, rd, wr, fetch, dma} <= {~a, 5'h00};
      #1 s = s | {ram_sel, rom_sel, oe};
      rf += ref_act;
    end
  endtask
  // Holds the processor in reset or in wait states, counting refreshes.
  task automatic hold(input logic rst, output int rf);
    rf = 0;
    @(posedge clock);
    cpu_rst_n <= !rst;
    waitc <= !rst;
    repeat (12) begin
      @(posedge clock);
      #1 rf += ref_act;
    end
    @(posedge clock);
    {cpu_rst_n, waitc} <= 2'h2;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: dv/moc_tb.sv
// Self-checking bench for the memory control block.
`default_nettype none
`include "moc_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTRL = `MOC_CTRL_IDX << 2;
  logic clock = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = '0, ara = '0, wd = '0;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp;
  wire [15:0] addr;
  wire awr, wrd, bv, arr, rv, req, rd, wr, fetch, waitc, dma, cpu_rst_n, ram_sel, rom_sel, oe, ref_act;
  int miscompares = 0, total_checks = 0, rf;
  logic [2:0] s;
  always #12.5 clock = ~clock;
  moc_memory_control dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata({24'h0, wd}), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .mem_addr(addr), .mem_req(req), .mem_rd(rd), .mem_wr(wr), .opcode_fetch_cycle(fetch), .cpu_wait(waitc),
    .dma_active(dma), .cpu_reset_n(cpu_rst_n), .ram_select_q(ram_sel), .rom_select_q(rom_sel), .data_oe_q(oe),
    .dram_ras_n_q(), .dram_cas_n_q(), .dram_we_n_q(), .dram_row_q(), .dram_col_q(), .refresh_active_q(ref_act));
  moc_host_model host (.clock, .ram_sel, .rom_sel, .oe, .ref_act, .addr, .req, .rd, .wr, .fetch, .waitc, .dma,
    .cpu_rst_n);
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  // Control write; address and data go out together, each is released at the
  // edge that takes it, and bready stands until the response is seen there.
  task automatic axi_wr(input logic [7:0] d);
    logic ta, tw, tk;
    logic [1:0] gr;
    @(posedge clock);
    {awa, wd, awv, wv, br} <= {CTRL, d, 3'h7};
    do begin
      @(negedge clock);
      ta = awv & awr;
      tw = wv & wrd;
      tk = br & bv;
      gr = bresp;
      @(posedge clock);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tk) br <= 1'b0;
    end while (!tk);
    chk("bresp", `MOC_RESP_OKAY, gr);
  endtask
  // Register read; rready stands from the start so the answer is taken at the
  // first edge at which rvalid is high.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tk;
    logic [31:0] gd;
    logic [1:0] gr;
    @(posedge clock);
    {ara, arv, rr} <= {a, 2'h3};
    do begin
      @(negedge clock);
      ta = arv & arr;
      tk = rr & rv;
      gd = rdata;
      gr = rresp;
      @(posedge clock);
      if (ta) arv <= 1'b0;
      if (tk) rr <= 1'b0;
    end while (!tk);
    chk("rdata", ed, gd);
    chk("rresp", er, gr);
  endtask
  task automatic t_rom();
    axi_rd(CTRL, 32'h4f, `MOC_RESP_OKAY);
    host.cyc(16'hf123, 1'b1, 1'b0, 1'b0, s, rf);
    chk("rom on", 3'h3, s);
    axi_wr(8'h6f);
    host.cyc(16'hf123, 1'b1, 1'b0, 1'b0, s, rf);
    chk("rom off", 3'h5, s);
    host.hold(1'b1, rf);
    chk("reset refresh", 1, rf > 1);
    axi_rd(CTRL, 32'h4f, `MOC_RESP_OKAY);
    axi_rd(8'h00, 0, `MOC_RESP_SLVERR);
  endtask
  // Each segment switched off in turn while its opposite stays on.
  task automatic t_seg();
    for (int n = 0; n < 4; n++) begin
      axi_wr(8'h6f & ~(8'h01 << n));
      host.cyc({n[1:0], 14'h00a5}, 1'b1, 1'b0, 1'b0, s, rf);
      chk("seg off", 3'h0, s);
      host.cyc({~n[1:0], 14'h035a}, 1'b1, 1'b0, 1'b0, s, rf);
      chk("seg on", 3'h5, s);
    end
  endtask
  task automatic t_ref();
    axi_wr(8'h4f);
    host.cyc(16'h1234, 1'b1, 1'b1, 1'b0, s, rf);
    chk("fetch refresh", 1, rf);
    host.cyc(16'h1234, 1'b1, 1'b0, 1'b0, s, rf);
    chk("no refresh", 0, rf);
    host.hold(1'b0, rf);
    chk("wait refresh", 1, rf > 1);
    host.cyc(16'h4321, 1'b0, 1'b0, 1'b1, s, rf);
    chk("dma write", 3'h4, s);
    host.cyc(16'h4322, 1'b1, 1'b0, 1'b1, s, rf);
    chk("dma read", 3'h5, s);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_rom();
    t_seg();
    t_ref();
    give_verdict();
  end
  // The run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #100us;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
